//--- src/mpel_pkg.sv
// Shared constants, types and register map of the master election block.
package mpel_pkg;

  localparam int MAX_DEV       = 6;
  localparam int ID_W          = 3;
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_TIME_NS  = 1000000;
  localparam int TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;

  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_DELAYA = 8'h04;
  localparam logic [7:0] REG_DELAYB = 8'h08;
  localparam logic [7:0] REG_RESP   = 8'h0C;
  localparam logic [7:0] REG_APP    = 8'h10;
  localparam logic [7:0] REG_PUMPS  = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;

  localparam int CTRL_ARCH_LSB  = 0;
  localparam int CTRL_ROLE_LSB  = 2;
  localparam int CTRL_ENASG_BIT = 4;
  localparam int CTRL_BOOST_BIT = 5;
  localparam int CTRL_ID_LSB    = 8;
  localparam int CTRL_NDEV_LSB  = 12;

  localparam logic [31:0] CTRL_RESET   = 32'h0000_1000;
  localparam logic [31:0] DELAYA_RESET = 32'h000A_000A;
  localparam logic [31:0] DELAYB_RESET = 32'h0064_0000;
  localparam logic [15:0] TICK_ONE     = 16'h0001;

  typedef enum logic [1:0] {
    ARCH_MONO_PUMP,
    ARCH_SINGLE_DRIVE,
    ARCH_MULTI_DRIVES,
    ARCH_MULTI_MASTERS
  } mpel_arch_type;

  typedef enum logic [1:0] {
    ROLE_SLAVE,
    ROLE_MASTER,
    ROLE_MASTER_ONLY,
    ROLE_MASTER_OR_SLAVE
  } mpel_role_type;

  typedef struct packed {
    logic woken;
    logic primed;
    logic filled;
  } mpel_app_type;

  typedef struct packed {
    logic              valid;
    logic [ID_W-1:0]   id;
    logic              claimsMaster;
    logic              primary;
    logic              ready;
    mpel_app_type      app;
  } mpel_link_rx_type;

  typedef struct packed {
    logic [ID_W-1:0]   id;
    logic              claimsMaster;
    logic              primary;
    logic              ready;
    mpel_app_type      app;
  } mpel_link_tx_type;

  typedef struct packed {
    logic [1:0] lead;
    logic [1:0] peer;
    logic [1:0] link;
  } mpel_resp_type;

  typedef struct packed {
    logic antiJam;
    logic priming;
    logic pipeFill;
    logic flowPressMon;
    logic pid;
    logic sleepWake;
    logic friction;
    logic jockey;
    logic feedback;
  } mpel_func_type;

endpackage

//--- src/mpel_delay_timer.sv
// Tick counter that reports when an armed delay has run out.
`timescale 1ns/1ps
`default_nettype none
module mpel_delay_timer (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        arm,
  input  wire logic        tick,
  input  wire logic [16:0] limit,
  output logic             done
);
  logic [16:0] count_q;

  always_ff @(posedge sys_clk) begin
    if (reset || !arm) begin
      count_q <= '0;
    end else if (tick && count_q != '1) begin
      count_q <= count_q + 17'h00001;
    end
  end

  assign done = arm && (count_q >= limit);
endmodule
`default_nettype wire

//--- src/mpel_peer_watch.sv
// Silence watchdog that tracks whether one peer is still heard on the link.
`timescale 1ns/1ps
`default_nettype none
module mpel_peer_watch (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        enable,
  input  wire logic        rxHit,
  input  wire logic        tick,
  input  wire logic [15:0] timeout,
  output logic             alive
);
  logic [15:0] count_q;
  logic        alive_q;

  always_ff @(posedge sys_clk) begin
    if (reset || !enable) begin
      count_q <= '0;
      alive_q <= 1'b0;
    end else if (rxHit) begin
      count_q <= '0;
      alive_q <= 1'b1;
    end else if (tick && alive_q) begin
      if (count_q >= timeout) begin
        alive_q <= 1'b0;
      end else begin
        count_q <= count_q + mpel_pkg::TICK_ONE;
      end
    end
  end

  assign alive = alive_q;
endmodule
`default_nettype wire

//--- src/mpel_master_election.sv
// Master election and group supervision for a drive in a linked pump group.
`timescale 1ns/1ps
`default_nettype none
module mpel_master_election #(
  parameter int TICK_CYCLES = mpel_pkg::TICK_CYCLES
) (
  input  wire logic                       sys_clk,
  input  wire logic                       reset,
  input  wire logic [7:0]                 avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [31:0]                avs_writedata,
  output logic [31:0]                     avs_readdata,
  output logic                            avs_waitrequest,
  input  wire logic                       runCmd,
  input  wire logic                       systemRunning,
  input  wire logic                       errorNonSystem,
  input  wire logic                       masterEnableIn,
  input  wire logic [3:0]                 availablePumps,
  input  wire logic                       leadPumpAvail,
  input  wire logic                       localPumpCtrl,
  input  wire logic                       primingRequest,
  input  wire mpel_pkg::mpel_app_type     appEvent,
  input  wire mpel_pkg::mpel_link_rx_type linkRx,
  output mpel_pkg::mpel_link_tx_type      linkTx,
  output logic                            masterActiveOut,
  output logic [mpel_pkg::ID_W-1:0]       activeMasterId,
  output logic                            capacityWarning,
  output logic                            leadPumpWarning,
  output logic                            leadPumpError,
  output logic                            peerDeviceWarning,
  output logic                            peerDeviceError,
  output logic                            linkConsistencyError,
  output mpel_pkg::mpel_resp_type         errorResponse,
  output mpel_pkg::mpel_func_type         functionEnable,
  output logic                            primingPumpCtrl
);
  localparam int MD = mpel_pkg::MAX_DEV;
  localparam int IW = mpel_pkg::ID_W;

  logic [31:0]            ctrl_q;
  logic [31:0]            delayA_q;
  logic [31:0]            delayB_q;
  mpel_pkg::mpel_resp_type respCfg_q;
  logic [3:0]             requested_q;
  mpel_pkg::mpel_app_type appState_q;
  logic                   ack_q;
  logic [15:0]            tickCnt_q;
  logic                   tick;
  logic                   actingMaster_q;
  logic                   poweredUp_q;
  logic                   runPrev_q;
  logic                   leadRunning_q;
  logic                   leadLost_q;
  logic                   noneAtRun_q;
  logic                   dupSeen_q;
  logic [MD-1:0]          peerClaims_q;
  logic [MD-1:0]          peerPrimary_q;
  logic [MD-1:0]          peerReady_q;
  mpel_pkg::mpel_app_type peerApp_q [MD];
  logic [MD-1:0]          peerAlive;
  logic [MD-1:0]          rxHit;
  logic [MD-1:0]          expected;

  mpel_pkg::mpel_arch_type arch;
  mpel_pkg::mpel_role_type role;
  logic [IW-1:0]          ownId;
  logic [3:0]             nbDevices;
  logic                   enAssigned;
  logic                   boosterLevelCfg;
  logic                   archMulti;
  logic                   roleCanMaster;
  logic                   qualify;
  logic                   contend;
  logic                   betterMaster;
  logic                   primaryPresent;
  logic                   electDone;
  logic                   devTimerDone;
  logic                   readyTimerDone;
  logic                   devWarn;
  logic                   inconsistent;
  logic                   regWrite;
  logic [16:0]            electLimit;
  logic [IW-1:0]          peerMasterId;

  // Lowest identifier among live peers that claim the master role.
  function automatic logic [IW-1:0] lowestClaim(input logic [MD-1:0] claims);
    logic [IW-1:0] id;
    id = '0;
    for (int i = MD - 1; i >= 0; i--) begin
      if (claims[i]) begin
        id = IW'(i + 1);
      end
    end
    return id;
  endfunction

  assign arch            = mpel_pkg::mpel_arch_type'(ctrl_q[mpel_pkg::CTRL_ARCH_LSB +: 2]);
  assign role            = mpel_pkg::mpel_role_type'(ctrl_q[mpel_pkg::CTRL_ROLE_LSB +: 2]);
  assign enAssigned      = ctrl_q[mpel_pkg::CTRL_ENASG_BIT];
  assign boosterLevelCfg = ctrl_q[mpel_pkg::CTRL_BOOST_BIT];
  assign ownId           = ctrl_q[mpel_pkg::CTRL_ID_LSB +: IW];
  assign nbDevices       = ctrl_q[mpel_pkg::CTRL_NDEV_LSB +: 4];
  assign archMulti       = (arch == mpel_pkg::ARCH_MULTI_DRIVES) ||
                           (arch == mpel_pkg::ARCH_MULTI_MASTERS);

  // Bus slave: one wait cycle, then the access completes.
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign regWrite        = avs_write && ack_q;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read || avs_write) && !ack_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ctrl_q      <= mpel_pkg::CTRL_RESET;
      delayA_q    <= mpel_pkg::DELAYA_RESET;
      delayB_q    <= mpel_pkg::DELAYB_RESET;
      respCfg_q   <= '0;
      requested_q <= '0;
    end else if (regWrite) begin
      unique case (avs_address)
        mpel_pkg::REG_CTRL:   ctrl_q      <= avs_writedata;
        mpel_pkg::REG_DELAYA: delayA_q    <= avs_writedata;
        mpel_pkg::REG_DELAYB: delayB_q    <= avs_writedata;
        mpel_pkg::REG_RESP:   respCfg_q   <= avs_writedata[5:0];
        mpel_pkg::REG_PUMPS:  requested_q <= avs_writedata[3:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      avs_readdata <= '0;
    end else if (avs_read && !ack_q) begin
      unique case (avs_address)
        mpel_pkg::REG_CTRL:   avs_readdata <= ctrl_q;
        mpel_pkg::REG_DELAYA: avs_readdata <= delayA_q;
        mpel_pkg::REG_DELAYB: avs_readdata <= delayB_q;
        mpel_pkg::REG_RESP:   avs_readdata <= {26'h0, respCfg_q};
        mpel_pkg::REG_APP:    avs_readdata <= {29'h0, appState_q};
        mpel_pkg::REG_PUMPS:  avs_readdata <= {28'h0, requested_q};
        mpel_pkg::REG_STATUS: avs_readdata <= {15'h0, peerAlive, 1'b0, activeMasterId,
                                               linkConsistencyError, peerDeviceError,
                                               peerDeviceWarning, leadPumpError,
                                               leadPumpWarning, capacityWarning,
                                               actingMaster_q};
        default:              avs_readdata <= '0;
      endcase
    end
  end

  // Time base for all configured delays.
  always_ff @(posedge sys_clk) begin
    if (reset || tick) begin
      tickCnt_q <= '0;
    end else begin
      tickCnt_q <= tickCnt_q + mpel_pkg::TICK_ONE;
    end
  end
  assign tick = (tickCnt_q == 16'(TICK_CYCLES - 1));

  // Peer table, fed by every frame received over the link whose identifier is 1 to MD and not ownId.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      peerClaims_q  <= '0;
      peerPrimary_q <= '0;
      peerReady_q   <= '0;
      for (int i = 0; i < MD; i++) begin
        peerApp_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < MD; i++) begin
        if (rxHit[i]) begin
          peerClaims_q[i]  <= linkRx.claimsMaster;
          peerPrimary_q[i] <= linkRx.primary;
          peerReady_q[i]   <= linkRx.ready;
          peerApp_q[i]     <= linkRx.app;
        end
      end
    end
  end

  for (genvar g = 0; g < MD; g++) begin : g_peer
    assign rxHit[g]    = linkRx.valid && (linkRx.id == IW'(g + 1)) && (ownId != IW'(g + 1));
    assign expected[g] = (4'(g + 1) <= nbDevices) && (ownId != IW'(g + 1));
    mpel_peer_watch u_watch (
      .sys_clk (sys_clk),
      .reset   (reset),
      .enable  (archMulti),
      .rxHit   (rxHit[g]),
      .tick    (tick),
      .timeout (delayB_q[31:16]),
      .alive   (peerAlive[g])
    );
  end

  // Election conditions and arbitration between live candidates.
  always_comb begin
    roleCanMaster = ((role == mpel_pkg::ROLE_MASTER) && (arch == mpel_pkg::ARCH_MULTI_DRIVES)) ||
                    (((role == mpel_pkg::ROLE_MASTER_ONLY) ||
                      (role == mpel_pkg::ROLE_MASTER_OR_SLAVE)) &&
                     (arch == mpel_pkg::ARCH_MULTI_MASTERS));
    betterMaster  = 1'b0;
    for (int i = 0; i < MD; i++) begin
      if (peerAlive[i] && peerClaims_q[i] &&
          ((peerPrimary_q[i] && role != mpel_pkg::ROLE_MASTER_ONLY) ||
           ((peerPrimary_q[i] == (role == mpel_pkg::ROLE_MASTER_ONLY)) &&
            (IW'(i + 1) < ownId)))) begin
        betterMaster = 1'b1;
      end
    end
  end

  assign primaryPresent = |(peerAlive & peerPrimary_q);
  assign qualify = runCmd && !errorNonSystem && (!enAssigned || masterEnableIn) &&
                   roleCanMaster;
  assign contend = qualify && !betterMaster &&
                   !((role == mpel_pkg::ROLE_MASTER_OR_SLAVE) && primaryPresent);
  assign electLimit = poweredUp_q ? {1'b0, delayA_q[31:16]} : {1'b0, delayA_q[15:0]};

  mpel_delay_timer u_elect (
    .sys_clk (sys_clk),
    .reset   (reset),
    .arm     (contend && !actingMaster_q),
    .tick    (tick),
    .limit   (electLimit),
    .done    (electDone)
  );

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      actingMaster_q <= 1'b0;
      poweredUp_q    <= 1'b0;
    end else if (!contend) begin
      actingMaster_q <= 1'b0;
    end else if (electDone) begin
      actingMaster_q <= 1'b1;
      poweredUp_q    <= 1'b1;
    end
  end

  assign peerMasterId = lowestClaim(peerAlive & peerClaims_q);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      masterActiveOut <= 1'b0;
      activeMasterId  <= '0;
    end else begin
      masterActiveOut <= actingMaster_q;
      activeMasterId  <= actingMaster_q ? ownId : peerMasterId;
    end
  end

  // Application status follows the acting master and survives a handover.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      appState_q <= '0;
    end else if (actingMaster_q) begin
      appState_q <= ((regWrite && avs_address == mpel_pkg::REG_APP) ?
                     mpel_pkg::mpel_app_type'(avs_writedata[2:0]) : appState_q) | appEvent;
    end else if (peerMasterId != '0 && rxHit[peerMasterId - IW'(1)]) begin
      appState_q <= linkRx.app;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      linkTx <= '0;
    end else begin
      linkTx.id           <= ownId;
      linkTx.claimsMaster <= actingMaster_q;
      linkTx.primary      <= (role == mpel_pkg::ROLE_MASTER_ONLY);
      linkTx.ready        <= runCmd && !errorNonSystem;
      linkTx.app          <= appState_q;
    end
  end

  // Lead pump supervision for the single-drive architecture.
  mpel_delay_timer u_ready (
    .sys_clk (sys_clk),
    .reset   (reset),
    .arm     (noneAtRun_q),
    .tick    (tick),
    .limit   ({1'b0, delayB_q[15:0]}),
    .done    (readyTimerDone)
  );

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      runPrev_q     <= 1'b0;
      leadRunning_q <= 1'b0;
      leadLost_q    <= 1'b0;
      noneAtRun_q   <= 1'b0;
      leadPumpError <= 1'b0;
    end else begin
      runPrev_q <= runCmd;
      if (!runCmd || arch != mpel_pkg::ARCH_SINGLE_DRIVE) begin
        leadRunning_q <= 1'b0;
        leadLost_q    <= 1'b0;
        noneAtRun_q   <= 1'b0;
        leadPumpError <= 1'b0;
      end else begin
        leadRunning_q <= leadPumpAvail;
        if (leadRunning_q && !leadPumpAvail) begin
          leadLost_q <= 1'b1;
          if (boosterLevelCfg) begin
            leadPumpError <= 1'b1;
          end
        end
        if (!runPrev_q && !leadPumpAvail) begin
          noneAtRun_q <= 1'b1;
        end else if (leadPumpAvail) begin
          noneAtRun_q <= 1'b0;
        end
        if (readyTimerDone && boosterLevelCfg) begin
          leadPumpError <= 1'b1;
        end
      end
    end
  end

  assign leadPumpWarning = leadLost_q || noneAtRun_q;

  // Device supervision over the link.
  assign devWarn = archMulti && (actingMaster_q ? |(expected & (~peerAlive | ~peerReady_q))
                                                : (peerMasterId == '0));

  mpel_delay_timer u_device (
    .sys_clk (sys_clk),
    .reset   (reset),
    .arm     (devWarn && systemRunning && runCmd && !actingMaster_q),
    .tick    (tick),
    .limit   ({delayA_q[31:16], 1'b1}),
    .done    (devTimerDone)
  );

  assign inconsistent = dupSeen_q ||
                        (actingMaster_q && (peerMasterId != '0)) ||
                        ((peerAlive & peerClaims_q) != '0 &&
                         ((peerAlive & peerClaims_q) & ((peerAlive & peerClaims_q) - 1'b1)) != '0);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      dupSeen_q            <= 1'b0;
      peerDeviceWarning    <= 1'b0;
      peerDeviceError      <= 1'b0;
      linkConsistencyError <= 1'b0;
      capacityWarning      <= 1'b0;
    end else begin
      dupSeen_q <= runCmd && (dupSeen_q || (linkRx.valid && linkRx.id == ownId && archMulti));
      peerDeviceWarning <= devWarn;
      peerDeviceError   <= devTimerDone && !actingMaster_q;
      linkConsistencyError <= runCmd && (arch == mpel_pkg::ARCH_MULTI_DRIVES) &&
                              (linkConsistencyError || inconsistent);
      capacityWarning <= (arch != mpel_pkg::ARCH_MONO_PUMP) &&
                         ((requested_q > availablePumps) || (availablePumps == 4'h0));
    end
  end

  // Error responses, role-dependent functions and priming control.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      errorResponse   <= '0;
      functionEnable  <= '0;
      primingPumpCtrl <= 1'b0;
    end else begin
      errorResponse.lead <= leadPumpError ? respCfg_q.lead : 2'h0;
      errorResponse.peer <= peerDeviceError ? respCfg_q.peer : 2'h0;
      errorResponse.link <= linkConsistencyError ? respCfg_q.link : 2'h0;
      functionEnable <= {2'b11, {7{!(archMulti && role == mpel_pkg::ROLE_SLAVE)}}};
      primingPumpCtrl <= primingRequest &&
                         (!archMulti || actingMaster_q || localPumpCtrl);
    end
  end

endmodule
`default_nettype wire

//--- testbench/mpel_master_election_props.sv
// Port checker for the master election block.
`timescale 1ns/1ps
`default_nettype none
module mpel_master_election_props (
  input wire logic                          sys_clk,
  input wire logic                          reset,
  input wire logic                          runCmd,
  input wire logic                          systemRunning,
  input wire logic                          localPumpCtrl,
  input wire logic [3:0]                    availablePumps,
  input wire mpel_pkg::mpel_link_tx_type    linkTx,
  input wire logic                          masterActiveOut,
  input wire logic [mpel_pkg::ID_W-1:0]     activeMasterId,
  input wire logic                          capacityWarning,
  input wire logic                          leadPumpWarning,
  input wire logic                          leadPumpError,
  input wire logic                          peerDeviceWarning,
  input wire logic                          peerDeviceError,
  input wire mpel_pkg::mpel_resp_type       errorResponse,
  input wire mpel_pkg::mpel_func_type       functionEnable,
  input wire logic                          primingPumpCtrl,
  input wire logic [7:0]                    avs_address,
  input wire logic                          avs_write,
  input wire logic                          avs_waitrequest,
  input wire logic [31:0]                   avs_writedata
);
  logic [1:0] archSeen_q;

  // Architecture field as last written over the bus, so that mono-pump can be told apart.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      archSeen_q <= 2'h0;
    end else if (avs_write && !avs_waitrequest && avs_address == mpel_pkg::REG_CTRL) begin
      archSeen_q <= avs_writedata[mpel_pkg::CTRL_ARCH_LSB +: 2];
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  a_func_always: assert property (!$past(reset) |-> functionEnable.antiJam &&
    functionEnable.priming) else $error("Anti-jam or priming disabled.");
  a_cap_zero: assert property ((archSeen_q != 2'h0 && availablePumps == 4'h0)[*4] |->
    capacityWarning) else $error("No capacity warning with zero pumps.");
  a_deverr_slave: assert property (peerDeviceError |-> !masterActiveOut)
    else $error("Device error on acting master.");
  a_deverr_cause: assert property ($rose(peerDeviceError) |->
    $past(peerDeviceWarning && runCmd && systemRunning)) else $error("Device error without cause.");
  a_resp_idle: assert property (!peerDeviceError && !$past(peerDeviceError) |->
    errorResponse.peer == 2'h0) else $error("Response shown without error.");
  a_master_id: assert property (masterActiveOut[*3] |-> activeMasterId == linkTx.id)
    else $error("Master does not report its own identifier.");
  a_prime_local: assert property ((!functionEnable.pipeFill && !localPumpCtrl)[*3]
    |-> !primingPumpCtrl) else $error("Slave drives priming pump.");
  a_lead_clear: assert property ((!runCmd)[*3] |-> !leadPumpWarning && !leadPumpError)
    else $error("Lead pump fault without run.");
  c_master: cover property ($rose(masterActiveOut));
  c_deverr: cover property ($rose(peerDeviceError));
  c_capwarn: cover property ($rose(capacityWarning));
endmodule
bind mpel_master_election mpel_master_election_props u_props (.sys_clk, .reset, .runCmd,
  .systemRunning, .localPumpCtrl, .availablePumps, .linkTx, .masterActiveOut, .activeMasterId,
  .capacityWarning, .leadPumpWarning, .leadPumpError, .peerDeviceWarning, .peerDeviceError,
  .errorResponse, .functionEnable, .primingPumpCtrl, .avs_address, .avs_write, .avs_waitrequest,
  .avs_writedata);
`default_nettype wire

//--- testbench/mpel_peer_model.sv
// Peer drive that sends status frames over the link.
`timescale 1ns/1ps
`default_nettype none
module mpel_peer_model (
  input  wire logic                  sys_clk,
  input  wire logic                  reset,
  input  wire logic                  talk,
  input  wire logic                  claims,
  output mpel_pkg::mpel_link_rx_type linkRx
);
  logic [3:0] gap_q;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      gap_q  <= 4'h0;
      linkRx <= '0;
    end else begin
      gap_q <= gap_q + 4'h1;
      if (talk && gap_q == 4'h0) begin
        linkRx <= {1'b1, 3'h2, claims, 1'b0, 1'b1, 3'h0};
      end else begin
        linkRx <= {1'b0, ~linkRx[8:0]};
      end
    end
  end
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
// Self-checking bench for the master election block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                       sys_clk;
  logic                       reset;
  logic [7:0]                 avs_address;
  logic                       avs_read;
  logic                       avs_write;
  logic [31:0]                avs_writedata;
  logic [31:0]                avs_readdata;
  logic                       avs_waitrequest;
  logic                       runCmd;
  logic                       systemRunning;
  logic                       errorNonSystem;
  logic                       masterEnableIn;
  logic [3:0]                 availablePumps;
  logic                       leadPumpAvail;
  logic                       localPumpCtrl;
  logic                       primingRequest;
  logic                       talk;
  logic                       claims;
  logic                       masterActiveOut;
  logic                       peerDeviceWarning;
  logic                       peerDeviceError;
  logic                       capacityWarning;
  logic [3:0]                 req;
  logic [31:0]                rd;
  mpel_pkg::mpel_app_type     appEvent;
  mpel_pkg::mpel_link_rx_type linkRx;
  mpel_pkg::mpel_resp_type    errorResponse;
  mpel_pkg::mpel_func_type    functionEnable;
  int                         failures = 0;
  int                         cmp_count = 0;
  int                         n;
  mpel_master_election #(.TICK_CYCLES(4)) DUT (.sys_clk, .reset, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .runCmd, .systemRunning,
    .errorNonSystem, .masterEnableIn, .availablePumps, .leadPumpAvail, .localPumpCtrl,
    .primingRequest, .appEvent, .linkRx, .linkTx(), .masterActiveOut, .activeMasterId(),
    .capacityWarning, .leadPumpWarning(), .leadPumpError(), .peerDeviceWarning,
    .peerDeviceError, .linkConsistencyError(), .errorResponse, .functionEnable,
    .primingPumpCtrl());
  mpel_peer_model PEER (.sys_clk, .reset, .talk, .claims, .linkRx);
  function automatic logic cap_exp(input logic [3:0] r, input logic [3:0] a);
    return (r > a) || (a == 4'h0);
  endfunction
  task automatic close_out;
    if (failures == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge sys_clk);
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    close_out();
  end
  initial begin
    {reset, avs_read, avs_write, avs_address, avs_writedata} = {1'b1, 42'h0};
    {runCmd, systemRunning, errorNonSystem, masterEnableIn, leadPumpAvail} = 5'h0;
    {localPumpCtrl, primingRequest, claims, appEvent, availablePumps} = 10'h0;
    talk = 1'b1;
    void'($urandom(32'h08C6));
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    bus(1'b0, mpel_pkg::REG_CTRL, 32'h0);
    chk(rd, mpel_pkg::CTRL_RESET);
    bus(1'b0, 8'h1C, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, mpel_pkg::REG_CTRL, 32'h0000_2106);
    bus(1'b1, mpel_pkg::REG_DELAYA, 32'h0002_0002);
    bus(1'b1, mpel_pkg::REG_DELAYB, 32'h0005_0003);
    bus(1'b1, mpel_pkg::REG_RESP, 32'h0000_0015);
    runCmd <= 1'b1;
    systemRunning <= 1'b1;
    n = 0;
    while (masterActiveOut !== 1'b1 && n < 200) begin
      n++;
      @(posedge sys_clk);
    end
    chk({31'h0, n >= 4 && n <= 20}, 32'h1);
    bus(1'b0, mpel_pkg::REG_STATUS, 32'h0);
    chk(rd & 32'h381, 32'h81);
    chk({23'h0, functionEnable}, 32'h1FF);
    appEvent <= 3'b100;
    @(posedge sys_clk);
    appEvent <= 3'b000;
    bus(1'b0, mpel_pkg::REG_APP, 32'h0);
    chk(rd & 32'h7, 32'h4);
    for (int i = 0; i < 8; i++) begin
      req = (i == 0) ? 4'h3 : 4'($urandom % 10);
      bus(1'b1, mpel_pkg::REG_PUMPS, {28'h0, req});
      availablePumps <= (i == 0) ? 4'h0 : 4'($urandom % 10);
      {masterEnableIn, leadPumpAvail, localPumpCtrl, primingRequest} <= 4'($urandom);
      repeat (4) @(posedge sys_clk);
      chk({31'h0, capacityWarning}, {31'h0, cap_exp(req, availablePumps)});
    end
    chk({31'h0, peerDeviceWarning}, 32'h0);
    talk <= 1'b0;
    repeat (60) @(posedge sys_clk);
    chk({31'h0, peerDeviceWarning}, 32'h1);
    bus(1'b1, mpel_pkg::REG_CTRL, 32'h0000_2102);
    claims <= 1'b1;
    talk <= 1'b1;
    repeat (40) @(posedge sys_clk);
    chk({30'h0, masterActiveOut, peerDeviceWarning}, 32'h0);
    bus(1'b0, mpel_pkg::REG_STATUS, 32'h0);
    chk(rd & 32'h3D1, 32'h100);
    talk <= 1'b0;
    repeat (100) @(posedge sys_clk);
    chk({31'h0, peerDeviceError}, 32'h1);
    chk({30'h0, errorResponse.peer}, 32'h1);
    bus(1'b1, mpel_pkg::REG_CTRL, 32'h0000_2121);
    leadPumpAvail <= 1'b1;
    repeat (4) @(posedge sys_clk);
    leadPumpAvail <= 1'b0;
    repeat (3) @(posedge sys_clk);
    bus(1'b0, mpel_pkg::REG_STATUS, 32'h0);
    chk(rd & 32'hC, 32'hC);
    chk({30'h0, errorResponse.lead}, 32'h1);
    runCmd <= 1'b0;
    @(posedge sys_clk);
    runCmd <= 1'b1;
    repeat (3) @(posedge sys_clk);
    bus(1'b0, mpel_pkg::REG_STATUS, 32'h0);
    chk(rd & 32'hC, 32'h4);
    repeat (20) @(posedge sys_clk);
    bus(1'b0, mpel_pkg::REG_STATUS, 32'h0);
    chk(rd & 32'hC, 32'hC);
    close_out();
  end
endmodule
`default_nettype wire
